// File: design/wim_pkg.sv
// Constants, types and register map of the wake-up and interrupt manager.
// Assumes one clock (mclk) and an asynchronous active-high reset.
// Operation
// [RULE1] Stop requested by control writes 1,0,1
// [RULE2] Stop needs NMI low, wake set, checks
// [RULE3] Unmasked line wake-up clears stop bit
// [RULE4] NMI wake-up leaves stop bit set
// [RULE5] Stop bit reads one in four cases
// [RULE6] External stop pin low forces stop
// [RULE7] Other register write cancels the sequence
// [RULE8] Write after sequence prevents stop entry
// [RULE9] Source select picks pin seven or lines
// [RULE10] Software masks, selects, clears, then unmasks
// [RULE11] Wake select makes lines wake-up sources
// [RULE12] Both select bits gate irq and wake; here line irq is gated by src_sel_ff only and line wake by wake_sel_ff only
// [RULE13] Masked line never wakes the device
// [RULE14] Polarity bit picks falling or rising edge
// [RULE15] Edge during polarity write is dropped
// [RULE16] Pending bit sticky, software may set
// [RULE17] Software clears pending by read-modify-write
// [RULE18] Wake-up lines must be glitch free
// [RULE19] Channel edge re-armed by clearing pending
// [RULE20] NMI rising edge or line ends stop
// [RULE21] Line request is OR of pending and mask
`default_nettype none
package wim_pkg;

  localparam int NUM_LINES = 16;
  localparam int SYNC_W    = 19;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL     = 8'hf9;
  localparam logic [7:0] ADDR_MASK_HI  = 8'hfa;
  localparam logic [7:0] ADDR_MASK_LO  = 8'hfb;
  localparam logic [7:0] ADDR_POL_HI   = 8'hfc;
  localparam logic [7:0] ADDR_POL_LO   = 8'hfd;
  localparam logic [7:0] ADDR_PEND_HI  = 8'hfe;
  localparam logic [7:0] ADDR_PEND_LO  = 8'hff;

  // Control field positions
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_SRC_BIT  = 1;
  localparam int CTRL_WAKE_BIT = 0;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_LINES = 16'h0000;
  localparam logic [18:0] RST_SYNC  = 19'h00000;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_GOT1    = 3'b001,
    ST_GOT0    = 3'b010,
    ST_ARMED   = 3'b011,
    ST_STOPPED = 3'b100
  } wim_stop_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wim_bus_req_t;

endpackage
`default_nettype wire

// File: design/wim_sync.sv
// Two-flop synchroniser for the asynchronous pins of the wake-up manager.
// Assumes inputs come from outside the mclk domain.
`timescale 1ns/100ps
`default_nettype none
module wim_sync #(
  parameter int W = 19
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // wim_sync
`default_nettype wire

// File: design/wim_top.sv
// Wake-up and interrupt manager: 16 edge lines, stop sequence, shared channel.
// Assumes a same-clock register port, stop_entered from the clock control unit.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module wim_top (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire wim_pkg::wim_bus_req_t bus_req,
  output logic [7:0]                reg_rdata,
  input  wire logic [15:0]          wake_lines,
  input  wire logic                 nmi_pin,
  input  wire logic                 ext_irq_pin_seven,
  input  wire logic                 stop_pin_n,
  input  wire logic                 other_reg_write,
  input  wire logic                 stop_entered,
  output logic                      shared_irq_channel,
  output logic                      stop_request,
  output logic                      wake_event
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [15:0] byte_update(
    input logic [15:0] cur,
    input logic        hi_wr,
    input logic        lo_wr,
    input logic [7:0]  wdata
  );
    logic [15:0] res;
    res = cur;
    if (hi_wr) begin
      res[15:8] = wdata;
    end
    if (lo_wr) begin
      res[7:0] = wdata;
    end
    return res;
  endfunction

  function automatic logic [15:0] edge_sel(
    input logic [15:0] pol,
    input logic [15:0] now,
    input logic [15:0] prev
  );
    return (pol & now & ~prev) | (~pol & ~now & prev);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [18:0] pins_s;
  logic [15:0] lines_s;
  logic        nmi_s;
  logic        irq7_s;
  logic        stop_n_s;

  wim_sync #(
    .W (wim_pkg::SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in ({wake_lines, nmi_pin, ext_irq_pin_seven, ~stop_pin_n}),
    .sync_out (pins_s)
  );

  assign lines_s  = pins_s[18:3];
  assign nmi_s    = pins_s[2];
  assign irq7_s   = pins_s[1];
  // Stop pin crosses inverted, so the flop reset value means idle
  assign stop_n_s = ~pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  wim_pkg::wim_stop_state_t state_ff;
  wim_pkg::wim_stop_state_t nxt_state;
  logic [15:0] mask_ff;
  logic [15:0] pol_ff;
  logic [15:0] pend_ff;
  logic [15:0] lines_prev_ff;
  logic        nmi_prev_ff;
  logic        stop_ff;
  logic        nxt_stop;
  logic        src_sel_ff;
  logic        wake_sel_ff;
  logic [7:0]  rdata_ff;
  logic        irq_ff;
  logic        stop_req_ff;
  logic        wake_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  wire        wr_ctrl    = bus_req.wr && (bus_req.addr == wim_pkg::ADDR_CTRL);
  wire        wr_mask_hi = bus_req.wr && (bus_req.addr == wim_pkg::ADDR_MASK_HI);
  wire        wr_mask_lo = bus_req.wr && (bus_req.addr == wim_pkg::ADDR_MASK_LO);
  wire        wr_pol_hi  = bus_req.wr && (bus_req.addr == wim_pkg::ADDR_POL_HI);
  wire        wr_pol_lo  = bus_req.wr && (bus_req.addr == wim_pkg::ADDR_POL_LO);
  wire        wr_pend_hi = bus_req.wr && (bus_req.addr == wim_pkg::ADDR_PEND_HI);
  wire        wr_pend_lo = bus_req.wr && (bus_req.addr == wim_pkg::ADDR_PEND_LO);
  wire        foreign_wr = (bus_req.wr && !wr_ctrl) || other_reg_write;
  wire        stop_wbit  = bus_req.wdata[wim_pkg::CTRL_STOP_BIT];
  wire        ctrl_stop1 = wr_ctrl && stop_wbit && !other_reg_write;
  wire        ctrl_stop0 = wr_ctrl && !stop_wbit && !other_reg_write;
  wire [15:0] pol_wr_blk = {{8{wr_pol_hi}}, {8{wr_pol_lo}}};

  ////////////////////////////////////////////////////////////////////////////
  // Line logic

  wire [15:0] edge_hit  = edge_sel(pol_ff, lines_s, lines_prev_ff) & ~pol_wr_blk; // RULE14 RULE15
  wire [15:0] nxt_pend  = byte_update(pend_ff, wr_pend_hi, wr_pend_lo, bus_req.wdata)
                          | edge_hit; // RULE16
  wire [15:0] nxt_mask  = byte_update(mask_ff, wr_mask_hi, wr_mask_lo, bus_req.wdata);
  wire [15:0] nxt_pol   = byte_update(pol_ff, wr_pol_hi, wr_pol_lo, bus_req.wdata);
  wire [15:0] live      = pend_ff & mask_ff;
  wire        line_req  = |live; // RULE21 RULE13
  wire        line_irq  = line_req && src_sel_ff; // RULE12
  wire        line_wake = line_req && wake_sel_ff; // RULE11 RULE12
  wire        nmi_rise  = nmi_s && !nmi_prev_ff; // RULE20
  wire        cond_ok   = wake_sel_ff && (live == 16'h0000) && (mask_ff != 16'h0000); // RULE2
  wire        nxt_irq   = src_sel_ff ? line_irq : irq7_s; // RULE9 RULE19

  ////////////////////////////////////////////////////////////////////////////
  // Stop sequence

  always_comb begin
    nxt_state = state_ff;
    nxt_stop  = stop_ff;
    case (state_ff)
      wim_pkg::ST_IDLE: begin
        if (ctrl_stop1) begin
          nxt_state = wim_pkg::ST_GOT1;
          nxt_stop  = 1'b1; // RULE5
        end else if (ctrl_stop0) begin
          nxt_stop = 1'b0;
        end
      end
      wim_pkg::ST_GOT1: begin
        if (foreign_wr) begin
          nxt_state = wim_pkg::ST_IDLE; // RULE7
          nxt_stop  = 1'b0;
        end else if (ctrl_stop0) begin
          nxt_state = wim_pkg::ST_GOT0; // RULE1
          nxt_stop  = 1'b0;
        end
      end
      wim_pkg::ST_GOT0: begin
        if (foreign_wr) begin
          nxt_state = wim_pkg::ST_IDLE; // RULE7
          nxt_stop  = 1'b0;
        end else if (ctrl_stop1) begin
          if (nmi_s) begin
            nxt_state = wim_pkg::ST_IDLE;
            nxt_stop  = 1'b1; // RULE5
          end else if (cond_ok) begin
            nxt_state = wim_pkg::ST_ARMED; // RULE1
            nxt_stop  = 1'b1;
          end else begin
            nxt_state = wim_pkg::ST_IDLE; // RULE2
            nxt_stop  = 1'b0;
          end
        end
      end
      wim_pkg::ST_ARMED: begin
        if (foreign_wr || wr_ctrl) begin
          nxt_state = wim_pkg::ST_IDLE; // RULE8
          nxt_stop  = 1'b0;
        end else if (stop_entered) begin
          nxt_state = wim_pkg::ST_STOPPED;
        end
      end
      wim_pkg::ST_STOPPED: begin
        if (line_wake) begin
          nxt_state = wim_pkg::ST_IDLE;
          nxt_stop  = 1'b0; // RULE3
        end else if (nmi_rise) begin
          nxt_state = wim_pkg::ST_IDLE; // RULE4
        end else if (!stop_entered) begin
          nxt_state = wim_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = wim_pkg::ST_IDLE;
        nxt_stop  = 1'b0;
      end
    endcase
  end

  wire nxt_stop_req = (nxt_state == wim_pkg::ST_ARMED) || (nxt_state == wim_pkg::ST_STOPPED)
                      || !stop_n_s; // RULE6
  wire nxt_wake     = (state_ff == wim_pkg::ST_STOPPED) && (line_wake || nmi_rise); // RULE20

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  wire [7:0] ctrl_view = {5'b00000, stop_ff, src_sel_ff, wake_sel_ff};
  wire [7:0] rd_val =
    (bus_req.addr == wim_pkg::ADDR_CTRL)    ? ctrl_view     :
    (bus_req.addr == wim_pkg::ADDR_MASK_HI) ? mask_ff[15:8] :
    (bus_req.addr == wim_pkg::ADDR_MASK_LO) ? mask_ff[7:0]  :
    (bus_req.addr == wim_pkg::ADDR_POL_HI)  ? pol_ff[15:8]  :
    (bus_req.addr == wim_pkg::ADDR_POL_LO)  ? pol_ff[7:0]   :
    (bus_req.addr == wim_pkg::ADDR_PEND_HI) ? pend_ff[15:8] :
    (bus_req.addr == wim_pkg::ADDR_PEND_LO) ? pend_ff[7:0]  :
    wim_pkg::RST_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_ff       <= wim_pkg::RST_LINES;
      pol_ff        <= wim_pkg::RST_LINES;
      pend_ff       <= wim_pkg::RST_LINES;
      lines_prev_ff <= wim_pkg::RST_LINES;
      nmi_prev_ff   <= 1'b0;
    end else begin
      mask_ff       <= nxt_mask;
      pol_ff        <= nxt_pol;
      pend_ff       <= nxt_pend;
      lines_prev_ff <= lines_s;
      nmi_prev_ff   <= nmi_s;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      src_sel_ff  <= 1'b0;
      wake_sel_ff <= 1'b0;
    end else if (wr_ctrl) begin
      src_sel_ff  <= bus_req.wdata[wim_pkg::CTRL_SRC_BIT];
      wake_sel_ff <= bus_req.wdata[wim_pkg::CTRL_WAKE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff    <= wim_pkg::ST_IDLE;
      stop_ff     <= 1'b0;
      stop_req_ff <= 1'b0;
      wake_ff     <= 1'b0;
      irq_ff      <= 1'b0;
      rdata_ff    <= wim_pkg::RST_BYTE;
    end else begin
      state_ff    <= nxt_state;
      stop_ff     <= nxt_stop;
      stop_req_ff <= nxt_stop_req;
      wake_ff     <= nxt_wake;
      irq_ff      <= nxt_irq;
      rdata_ff    <= bus_req.rd ? rd_val : wim_pkg::RST_BYTE;
    end
  end

  assign reg_rdata          = rdata_ff;
  assign shared_irq_channel = irq_ff;
  assign stop_request       = stop_req_ff;
  assign wake_event         = wake_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_first;
    state_ff == wim_pkg::ST_IDLE && ctrl_stop1;
  endsequence

  sequence s_second;
    state_ff == wim_pkg::ST_GOT1 && ctrl_stop0 && !foreign_wr;
  endsequence

  sequence s_third_ok;
    state_ff == wim_pkg::ST_GOT0 && ctrl_stop1 && !nmi_s && cond_ok;
  endsequence

  sequence s_third_bad;
    state_ff == wim_pkg::ST_GOT0 && ctrl_stop1 && !nmi_s && !cond_ok;
  endsequence

  chk_stop_sequence: // RULE1
    assert property (s_first ##[1:8] s_second ##[1:8] s_third_ok |=> stop_ff && stop_request)
    else $error("Correct stop sequence did not set stop and request");

  chk_stop_refused: // RULE2
    assert property (s_first ##[1:8] s_second ##[1:8] s_third_bad
                     |=> !stop_ff && state_ff == wim_pkg::ST_IDLE)
    else $error("Stop sequence accepted without its conditions");

  chk_line_wake_clear: // RULE3
    assert property (state_ff == wim_pkg::ST_STOPPED && line_wake
                     |=> !stop_ff && wake_event)
    else $error("Line wake-up did not clear stop bit");

  chk_nmi_keeps_stop: // RULE4
    assert property (state_ff == wim_pkg::ST_STOPPED && nmi_rise && !line_wake
                     |=> stop_ff && wake_event)
    else $error("NMI wake-up cleared the stop bit");

  chk_first_write: // RULE5
    assert property (s_first |=> stop_ff && state_ff == wim_pkg::ST_GOT1)
    else $error("First sequence write did not show stop bit");

  chk_ext_stop_pin: // RULE6
    assert property (!stop_n_s |=> stop_request)
    else $error("External stop pin did not force a stop request");

  chk_seq_cancel: // RULE7
    assert property (state_ff == wim_pkg::ST_GOT1 && other_reg_write
                     |=> state_ff == wim_pkg::ST_IDLE && !stop_ff)
    else $error("Foreign write did not cancel the sequence");

  chk_armed_cancel: // RULE8
    assert property (state_ff == wim_pkg::ST_ARMED && foreign_wr && stop_n_s
                     |=> !stop_request && !stop_ff)
    else $error("Write after sequence did not prevent stop entry");

  chk_channel_source: // RULE9
    assert property (!src_sel_ff |=> shared_irq_channel == $past(irq7_s))
    else $error("Channel not driven by pin seven");

  chk_edge_sets: // RULE14
    assert property (edge_hit != 16'h0000 |=> (pend_ff & $past(edge_hit)) == $past(edge_hit))
    else $error("Selected edge did not set pending bit");

  chk_pol_write_drop: // RULE15
    assert property (wr_pol_lo && pend_ff[7:0] == 8'h00 && !wr_pend_lo
                     |=> pend_ff[7:0] == 8'h00)
    else $error("Edge set pending during polarity write");

  chk_pend_sticky: // RULE16
    assert property (!wr_pend_hi && !wr_pend_lo |=> (pend_ff & $past(pend_ff)) == $past(pend_ff))
    else $error("Pending bit dropped without a write");

  chk_src_lines: // RULE9
    assert property (src_sel_ff |=> shared_irq_channel == $past(line_req))
    else $error("Channel not driven by the line request");

  chk_masked_no_wake: // RULE13
    assert property (live == 16'h0000 && !nmi_rise |=> !wake_event)
    else $error("Wake-up raised without an unmasked pending line");

  chk_wake_needs_stop: // RULE20
    assert property (state_ff != wim_pkg::ST_STOPPED |=> !wake_event)
    else $error("Wake-up raised outside stop mode");

endmodule // wim_top
`default_nettype wire

// File: testbench/wim_far_side.sv
// Far-side model: wake-up pins, NMI, pin seven and the CPU interrupt channel.
// Assumes the bench sets target pin levels just after rising mclk edges.
`timescale 1ns/100ps
`default_nettype none
module wim_far_side (
  input  wire logic        mclk,
  input  wire logic        slow,
  input  wire logic [17:0] level_set,
  input  wire logic        shared_irq_channel,
  input  wire logic        chan_unmask,
  output logic      [15:0] wake_lines,
  output logic             nmi_pin,
  output logic             ext_irq_pin_seven,
  output logic      [7:0]  irq_edges
);
  logic [17:0] stage1_ff = 18'h00000;
  logic [17:0] stage2_ff = 18'h00000;
  logic [17:0] stage3_ff = 18'h00000;
  logic        chan_prev_ff = 1'b0;
  logic [7:0]  edges_ff = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Pins move once per clock, never glitch; slow mode lags two cycles
  always_ff @(posedge mclk) begin
    stage1_ff <= level_set;
    stage2_ff <= stage1_ff;
    stage3_ff <= stage2_ff;
  end
  assign {nmi_pin, ext_irq_pin_seven, wake_lines} = slow ? stage3_ff : stage1_ff;
  ////////////////////////////////////////////////////////////////////////////
  // CPU side counts only rising edges of the shared channel
  always_ff @(posedge mclk) begin
    chan_prev_ff <= shared_irq_channel;
    if (chan_unmask && shared_irq_channel && !chan_prev_ff) begin
      edges_ff <= edges_ff + 8'h01;
    end
  end
  assign irq_edges = edges_ff;
endmodule // wim_far_side
`default_nettype wire

// File: testbench/tb_wim_top.sv
// Self-checking bench of the wake-up and interrupt manager.
// Assumes wim_pkg and wim_top are compiled first; mclk runs at 40 MHz.
`timescale 1ns/100ps
`default_nettype none
module tb_wim_top;
  typedef struct packed {logic src, wake, pol, start, fin, pend, irq;} wim_row_t;
  logic                  mclk = 1'b0;
  logic                  sys_rst = 1'b1;
  wim_pkg::wim_bus_req_t bus_req = '0;
  logic [17:0]           far_set = 18'h00000;
  logic                  slow = 1'b0;
  logic                  chan_unmask = 1'b1;
  logic                  stop_pin_n = 1'b1;
  logic                  other_reg_write = 1'b0;
  logic                  stop_entered = 1'b0;
  logic [7:0]            reg_rdata, irq_edges, e0;
  logic [15:0]           wake_lines;
  logic                  nmi_pin, ext_irq_pin_seven, shared_irq_channel, stop_request, wake_event;
  int                    n_fail = 0, check_count = 0;
  wim_row_t rows [5] = '{7'b1010111, 7'b1000100, 7'b1101011, 7'b0110110, 7'b0001010};
  always #12.5 mclk = ~mclk;
  wim_top i_wim_top (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .reg_rdata(reg_rdata),
    .wake_lines(wake_lines), .nmi_pin(nmi_pin), .ext_irq_pin_seven(ext_irq_pin_seven),
    .stop_pin_n(stop_pin_n), .other_reg_write(other_reg_write), .stop_entered(stop_entered),
    .shared_irq_channel(shared_irq_channel), .stop_request(stop_request), .wake_event(wake_event));
  wim_far_side i_wim_far_side (.mclk(mclk), .slow(slow), .level_set(far_set),
    .chan_unmask(chan_unmask),
    .shared_irq_channel(shared_irq_channel), .wake_lines(wake_lines), .nmi_pin(nmi_pin),
    .ext_irq_pin_seven(ext_irq_pin_seven), .irq_edges(irq_edges));
  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task ck(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus_req <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) bus_req <= '0;
    #1 ck(reg_rdata, exp);
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task stop_seq;
    wr(wim_pkg::ADDR_CTRL, 8'h05);
    wr(wim_pkg::ADDR_CTRL, 8'h01);
    wr(wim_pkg::ADDR_CTRL, 8'h05);
    wt(2);
  endtask
  task wait_wake;
    int i;
    for (i = 0; i < 14; i++) begin
      @(posedge mclk);
      #1;
      if (wake_event === 1'b1) break;
    end
    if (i == 14) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    wt(1);
    ck({5'h00, shared_irq_channel, stop_request, wake_event}, 8'h00);
    for (int a = 8'hf9; a <= 8'hff; a++) rd(a[7:0], 8'h00);
    rd(8'hf0, 8'h00);
    foreach (rows[k]) begin
      slow <= k[0];
      far_set[0] <= rows[k].start;
      wt(6);
      chan_unmask <= 1'b0;
      wr(wim_pkg::ADDR_CTRL, {6'h00, rows[k].src, rows[k].wake});
      wr(wim_pkg::ADDR_POL_LO, {7'h00, rows[k].pol});
      wr(wim_pkg::ADDR_MASK_LO, 8'h01);
      wr(wim_pkg::ADDR_PEND_LO, 8'h00);
      wt(2);
      e0 = irq_edges;
      chan_unmask <= 1'b1;
      far_set[0] <= rows[k].fin;
      wt(8);
      rd(wim_pkg::ADDR_PEND_LO, {7'h00, rows[k].pend});
      ck({7'h00, shared_irq_channel}, {7'h00, rows[k].irq});
      ck(irq_edges, e0 + {7'h00, rows[k].irq});
    end
    slow <= 1'b0;
    e0 = irq_edges;
    far_set[16] <= 1'b1;
    wt(6);
    ck({7'h00, shared_irq_channel}, 8'h01);
    ck(irq_edges, e0 + 8'h01);
    far_set[16] <= 1'b0;
    wr(wim_pkg::ADDR_POL_LO, 8'h01);
    wr(wim_pkg::ADDR_PEND_LO, 8'h00);
    wr(wim_pkg::ADDR_CTRL, 8'h05);
    rd(wim_pkg::ADDR_CTRL, 8'h05);
    wr(wim_pkg::ADDR_CTRL, 8'h01);
    wr(wim_pkg::ADDR_CTRL, 8'h05);
    wt(2);
    ck({7'h00, stop_request}, 8'h01);
    stop_entered <= 1'b1;
    far_set[0] <= 1'b1;
    wait_wake();
    rd(wim_pkg::ADDR_CTRL, 8'h01);
    ck({7'h00, stop_request}, 8'h00);
    stop_entered <= 1'b0;
    wr(wim_pkg::ADDR_PEND_LO, 8'h00);
    stop_seq();
    stop_entered <= 1'b1;
    far_set[17] <= 1'b1;
    wait_wake();
    rd(wim_pkg::ADDR_CTRL, 8'h05);
    stop_entered <= 1'b0;
    far_set[17] <= 1'b0;
    wr(wim_pkg::ADDR_CTRL, 8'h05);
    @(posedge mclk) other_reg_write <= 1'b1;
    @(posedge mclk) other_reg_write <= 1'b0;
    rd(wim_pkg::ADDR_CTRL, 8'h01);
    wr(wim_pkg::ADDR_CTRL, 8'h01);
    wr(wim_pkg::ADDR_CTRL, 8'h05);
    wt(2);
    ck({7'h00, stop_request}, 8'h00);
    rd(wim_pkg::ADDR_CTRL, 8'h05);
    stop_seq();
    wr(wim_pkg::ADDR_MASK_LO, 8'h01);
    wt(2);
    ck({7'h00, stop_request}, 8'h00);
    wr(wim_pkg::ADDR_CTRL, 8'h01);
    wr(wim_pkg::ADDR_MASK_LO, 8'h00);
    stop_seq();
    ck({7'h00, stop_request}, 8'h00);
    rd(wim_pkg::ADDR_CTRL, 8'h01);
    wr(wim_pkg::ADDR_MASK_LO, 8'h01);
    far_set[17] <= 1'b1;
    wt(4);
    stop_seq();
    ck({7'h00, stop_request}, 8'h00);
    rd(wim_pkg::ADDR_CTRL, 8'h05);
    far_set[17] <= 1'b0;
    stop_pin_n <= 1'b0;
    wt(5);
    ck({7'h00, stop_request}, 8'h01);
    stop_pin_n <= 1'b1;
    wr(wim_pkg::ADDR_PEND_HI, 8'h81);
    rd(wim_pkg::ADDR_PEND_HI, 8'h81);
    wr(wim_pkg::ADDR_PEND_HI, 8'h81 & 8'hfe);
    rd(wim_pkg::ADDR_PEND_HI, 8'h80);
    report_and_stop();
  end
endmodule // tb_wim_top
`default_nettype wire
